/* File: rtl/sacs_adc_ctrl.v */
`timescale 1ns/100ps
`include "sacs_defines.vh"
// Overview of operation
// - start bit launches conversion, self-clears
// - mode 00 off/stop, 01 single, 11 repeat
// - input gate zero disables all inputs
// - channel codes 0-7 route inputs, rest reserved
// - low-power entry clears start, mode, gate
// - end flag bit 7 set on completion
// - busy flag bit 6 while converting
// - time code sets 39..1248 cycle length
// - low-power entry clears end and busy
// - high read or new start clears end
// - control two bits 3-5 read zero
// - start and store overhead within bound
// - reference current only while converting
// - completion stores result, flags, interrupt
// - repeat restarts; mid-read completion discarded
// - mode 00 stops, clears flags and result
// - result split low eight, high two
module sacs_adc_ctrl (
  input wire clk_in,
  input wire rst_b_in,
  input wire [11:0] s_axi_awaddr_in,
  input wire s_axi_awvalid_in,
  output reg s_axi_awready_out,
  input wire [31:0] s_axi_wdata_in,
  input wire [3:0] s_axi_wstrb_in,
  input wire s_axi_wvalid_in,
  output reg s_axi_wready_out,
  output reg [1:0] s_axi_bresp_out,
  output reg s_axi_bvalid_out,
  input wire s_axi_bready_in,
  input wire [11:0] s_axi_araddr_in,
  input wire s_axi_arvalid_in,
  output reg s_axi_arready_out,
  output reg [31:0] s_axi_rdata_out,
  output reg [1:0] s_axi_rresp_out,
  output reg s_axi_rvalid_out,
  input wire s_axi_rready_in,
  input wire low_power_in,
  input wire comparator_in,
  output reg [7:0] analog_input_enable_out,
  output reg [9:0] dac_code_out,
  output reg dac_reference_current_out,
  output reg conversion_done_irq_out
);
  reg conv_start_bit;
  reg [1:0] op_mode_field;
  reg analog_input_gate;
  reg [3:0] channel_select;
  reg conversion_end_flag;
  reg conversion_active_flag;
  reg [2:0] time_code;
  reg [7:0] result_low;
  reg [1:0] result_high;
  reg low_read_pending;
  reg [1:0] lat_cnt;
  reg launching;
  reg aw_held;
  reg w_held;
  reg [11:0] aw_addr;
  reg [31:0] w_data;
  reg w_lane0;
  reg [10:0] length;
  wire [9:0] sar_trial;
  wire sar_done;
  wire [9:0] sar_result;
  wire sar_go;
  wire stop_now;
  wire do_write;
  wire wr_c1;
  wire wr_c2;
  wire rd_take;
  wire rd_resh;
  wire rd_resl;
  reg [7:0] rd_byte;
  reg rd_ok;
  // decoded write and completion events shared by the control blocks
  wire [7:0] next_gate;
  wire [1:0] wr_mode;
  wire start_ok;
  wire conv_finish;
  wire result_keep;
  wire aw_mapped;
  genvar gi;

  assign do_write = aw_held && w_held && !s_axi_bvalid_out;
  assign wr_c1 = do_write && w_lane0 && (aw_addr == `SACS_ADDR_CTRL1);
  assign wr_c2 = do_write && w_lane0 && (aw_addr == `SACS_ADDR_CTRL2);
  assign rd_take = s_axi_arvalid_in && s_axi_arready_out;
  assign rd_resh = rd_take && (s_axi_araddr_in == `SACS_ADDR_RESH);
  assign rd_resl = rd_take && (s_axi_araddr_in == `SACS_ADDR_RESL);
  // forced stop by mode 00 write, or entry to a low-power mode
  assign wr_mode = w_data[`SACS_C1_MODE_HI:`SACS_C1_MODE_LO];
  assign stop_now = low_power_in || (wr_c1 && wr_mode == `SACS_MODE_OFF);
  // a relaunch in repeat mode presets the counter so the next conversion starts at once
  assign sar_go = launching && (lat_cnt == `SACS_START_LAT) && !stop_now;
  // start accepted only in single or repeat mode and when idle
  assign start_ok = wr_c1 && w_data[`SACS_C1_START] && !conversion_active_flag &&
    (wr_mode == `SACS_MODE_SINGLE || wr_mode == `SACS_MODE_REPEAT);
  assign conv_finish = sar_done && conversion_active_flag;
  // a completion that falls between the low and high result reads is dropped
  assign result_keep = conv_finish && !(low_read_pending && !rd_resh);
  // writes to read-only or status registers answer okay and change nothing
  assign aw_mapped = (aw_addr == `SACS_ADDR_CTRL1) || (aw_addr == `SACS_ADDR_CTRL2) ||
    (aw_addr == `SACS_ADDR_RESL) || (aw_addr == `SACS_ADDR_RESH) || (aw_addr == `SACS_ADDR_PWR);

  always @* begin
    case (time_code)
      3'b000: length = `SACS_T0;
      3'b001: length = `SACS_T1;
      3'b010: length = `SACS_T2;
      3'b011: length = `SACS_T3;
      3'b100: length = `SACS_T4;
      3'b101: length = `SACS_T5;
      default: length = `SACS_T5; // reserved codes run the longest, safest time
    endcase
  end

  // each gate bit follows the channel decode only when the global gate is on
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_gate
      localparam [2:0] CODE = gi;
      assign next_gate[gi] = analog_input_gate && !channel_select[3] &&
        (channel_select[2:0] == CODE);
    end
  endgenerate

  always @* begin
    rd_ok = 1'b1;
    case (s_axi_araddr_in)
      `SACS_ADDR_CTRL1: rd_byte = {conv_start_bit, op_mode_field, analog_input_gate,
        channel_select};
      `SACS_ADDR_CTRL2: rd_byte = {conversion_end_flag, conversion_active_flag, 3'b000,
        time_code};
      `SACS_ADDR_RESL: rd_byte = result_low;
      `SACS_ADDR_RESH: rd_byte = {6'b00_0000, result_high};
      `SACS_ADDR_PWR: rd_byte = {7'b000_0000, low_power_in};
      default: begin
        rd_byte = 8'h00;
        rd_ok = 1'b0;
      end
    endcase
  end

  sacs_sar_core #(
    .BITS(10)
  ) u_sar (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .go_in(sar_go),
    .abort_in(stop_now),
    .length_in(length),
    .comp_in(comparator_in),
    .trial_out(sar_trial),
    .done_out(sar_done),
    .result_out(sar_result)
  );

  // bus slave: address and data accepted in either order, one write at a time
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s_axi_awready_out <= 1'b0;
      s_axi_wready_out <= 1'b0;
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= `SACS_RESP_OKAY;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 12'h000;
      w_data <= 32'h0000_0000;
      w_lane0 <= 1'b0;
    end else begin
      s_axi_awready_out <= !aw_held && !s_axi_awready_out && s_axi_awvalid_in;
      s_axi_wready_out <= !w_held && !s_axi_wready_out && s_axi_wvalid_in;
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_held <= 1'b1;
        aw_addr <= {s_axi_awaddr_in[11:2], 2'b00} | {10'h000, s_axi_awaddr_in[1:0]};
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata_in;
        w_lane0 <= s_axi_wstrb_in[0];
      end
      if (do_write) begin
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out <= aw_mapped ? `SACS_RESP_OKAY : `SACS_RESP_SLVERR;
      end
      if (s_axi_bvalid_out && s_axi_bready_in) begin
        s_axi_bvalid_out <= 1'b0;
        aw_held <= 1'b0;
        w_held <= 1'b0;
      end
    end
  end

  // read channel: one read at a time, answered the cycle after the address is taken
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= 32'h0000_0000;
      s_axi_rresp_out <= `SACS_RESP_OKAY;
    end else begin
      s_axi_arready_out <= !s_axi_arready_out && !s_axi_rvalid_out && s_axi_arvalid_in;
      if (rd_take) begin
        s_axi_rvalid_out <= 1'b1;
        s_axi_rdata_out <= {24'h00_0000, rd_byte};
        s_axi_rresp_out <= rd_ok ? `SACS_RESP_OKAY : `SACS_RESP_SLVERR;
      end else if (s_axi_rvalid_out && s_axi_rready_in) begin
        s_axi_rvalid_out <= 1'b0;
      end
    end
  end

  // configuration written by software; mode and gate cleared on low-power entry, channel and time code kept
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      op_mode_field <= `SACS_MODE_OFF;
      analog_input_gate <= 1'b0;
      channel_select <= 4'h0;
      time_code <= 3'b000;
    end else begin
      if (wr_c2) begin
        time_code <= w_data[2:0];
      end
      // reserved mode and channel codes are stored as written
      if (wr_c1) begin
        op_mode_field <= wr_mode;
        analog_input_gate <= w_data[`SACS_C1_GATE];
        channel_select <= w_data[`SACS_C1_CHAN_HI:0];
      end
      if (low_power_in) begin
        op_mode_field <= `SACS_MODE_OFF;
        analog_input_gate <= 1'b0;
      end
    end
  end

  // start bit and launch delay
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      conv_start_bit <= 1'b0;
      launching <= 1'b0;
      lat_cnt <= 2'd0;
    end else begin
      if (start_ok) begin
        conv_start_bit <= 1'b1;
        launching <= 1'b1;
        lat_cnt <= 2'd0;
      end
      if (launching) begin
        lat_cnt <= lat_cnt + 2'd1;
        if (sar_go) begin
          launching <= 1'b0;
          conv_start_bit <= 1'b0;
        end
      end
      if (conv_finish && op_mode_field == `SACS_MODE_REPEAT) begin
        launching <= 1'b1;
        lat_cnt <= `SACS_START_LAT;
      end
      if (stop_now) begin
        launching <= 1'b0;
        conv_start_bit <= 1'b0;
      end
    end
  end

  // status flags: a completion wins over a high-result read in the same cycle
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      conversion_end_flag <= 1'b0;
      conversion_active_flag <= 1'b0;
    end else begin
      if (start_ok) begin
        conversion_active_flag <= 1'b1;
        conversion_end_flag <= 1'b0;
      end
      if (rd_resh) begin
        conversion_end_flag <= 1'b0;
      end
      if (result_keep) begin
        conversion_end_flag <= 1'b1;
      end
      if (conv_finish && op_mode_field != `SACS_MODE_REPEAT) begin
        conversion_active_flag <= 1'b0;
      end
      if (stop_now) begin
        conversion_end_flag <= 1'b0;
        conversion_active_flag <= 1'b0;
      end
    end
  end

  // result registers; a low read arms the drop window, the high read closes it
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      result_low <= `SACS_RESET_8;
      result_high <= 2'b00;
      low_read_pending <= 1'b0;
    end else begin
      if (rd_resl) begin
        low_read_pending <= 1'b1;
      end else if (rd_resh) begin
        low_read_pending <= 1'b0;
      end
      if (result_keep) begin
        result_low <= sar_result[7:0];
        result_high <= sar_result[9:8];
      end
      if (stop_now) begin
        result_low <= `SACS_RESET_8;
        result_high <= 2'b00;
        low_read_pending <= 1'b0;
      end
    end
  end

  // pin-facing outputs, each straight from a flop
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      analog_input_enable_out <= 8'h00;
      dac_code_out <= 10'h000;
      dac_reference_current_out <= 1'b0;
      conversion_done_irq_out <= 1'b0;
    end else begin
      conversion_done_irq_out <= result_keep && !stop_now;
      analog_input_enable_out <= low_power_in ? 8'h00 : next_gate;
      dac_code_out <= sar_trial;
      // reference current tracks the live conversion only
      dac_reference_current_out <= conversion_active_flag && !launching && !stop_now;
    end
  end
endmodule // sacs_adc_ctrl

/* File: rtl/sacs_defines.vh */
`ifndef SACS_DEFINES_VH
`define SACS_DEFINES_VH
// byte addresses on the register bus: four times the register index
`define SACS_ADDR_CTRL1 12'h0D0
`define SACS_ADDR_CTRL2 12'h0D4
`define SACS_ADDR_RESL 12'h0D8
`define SACS_ADDR_RESH 12'h0DC
`define SACS_ADDR_PWR 12'h040
// register indices
`define SACS_IDX_CTRL1 10'h034
`define SACS_IDX_CTRL2 10'h035
`define SACS_IDX_RESL 10'h036
`define SACS_IDX_RESH 10'h037
// control one fields
`define SACS_C1_START 7
`define SACS_C1_MODE_HI 6
`define SACS_C1_MODE_LO 5
`define SACS_C1_GATE 4
`define SACS_C1_CHAN_HI 3
// control two fields
`define SACS_C2_END 7
`define SACS_C2_BUSY 6
`define SACS_RESET_8 8'h00
// mode codes
`define SACS_MODE_OFF 2'b00
`define SACS_MODE_SINGLE 2'b01
`define SACS_MODE_REPEAT 2'b11
// conversion lengths in core cycles
`define SACS_T0 11'd39
`define SACS_T1 11'd78
`define SACS_T2 11'd156
`define SACS_T3 11'd312
`define SACS_T4 11'd624
`define SACS_T5 11'd1248
`define SACS_START_LAT 2'd2
`define SACS_RESP_OKAY 2'b00
`define SACS_RESP_SLVERR 2'b10
`endif

/* File: rtl/sacs_sar_core.v */
`timescale 1ns/100ps
`include "sacs_defines.vh"
// successive approximation step engine: one comparator decision per step
module sacs_sar_core #(
  parameter BITS = 10
) (
  input wire clk_in,
  input wire rst_b_in,
  input wire go_in,
  input wire abort_in,
  input wire [10:0] length_in,
  input wire comp_in,
  output reg [BITS-1:0] trial_out,
  output reg done_out,
  output reg [BITS-1:0] result_out
);
  reg [10:0] cnt;
  reg [10:0] step_len;
  reg [3:0] bit_idx;
  reg active;
  integer i;
  localparam [3:0] TOP_IDX = BITS - 1;
  localparam [10:0] BITS_W = BITS;
  localparam [10:0] ROUND_UP = BITS - 1;
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cnt <= 11'h000;
      step_len <= 11'h000;
      bit_idx <= 4'h0;
      active <= 1'b0;
      trial_out <= {BITS{1'b0}};
      done_out <= 1'b0;
      result_out <= {BITS{1'b0}};
    end else begin
      done_out <= 1'b0;
      if (abort_in) begin
        active <= 1'b0;
        trial_out <= {BITS{1'b0}};
      end else if (go_in) begin
        active <= 1'b1;
        bit_idx <= TOP_IDX;
        // round the step up so the decisions never finish before the selected time
        step_len <= (length_in + ROUND_UP) / BITS_W;
        cnt <= 11'h000;
        trial_out <= {1'b1, {(BITS-1){1'b0}}};
      end else if (active) begin
        if (cnt + 11'h001 >= step_len) begin
          cnt <= 11'h000;
          for (i = 0; i < BITS; i = i + 1) begin
            if (i == bit_idx) begin
              trial_out[i] <= comp_in;
            end else if (i + 1 == bit_idx) begin
              trial_out[i] <= 1'b1;
            end
          end
          if (bit_idx == 4'h0) begin
            active <= 1'b0;
            done_out <= 1'b1;
            result_out <= {trial_out[BITS-1:1], comp_in};
          end else begin
            bit_idx <= bit_idx - 4'h1;
          end
        end else begin
          cnt <= cnt + 11'h001;
        end
      end
    end
  end
endmodule // sacs_sar_core

/* File: verif/sacs_adc_chk.sv */
`timescale 1ns/100ps
`include "sacs_defines.vh"
module sacs_adc_chk (
  input wire clk_in,
  input wire rst_b_in,
  input wire [11:0] s_axi_araddr_in,
  input wire s_axi_arvalid_in,
  input wire s_axi_arready_out,
  input wire [31:0] s_axi_rdata_out,
  input wire [1:0] s_axi_rresp_out,
  input wire s_axi_rvalid_out,
  input wire s_axi_rready_in,
  input wire low_power_in,
  input wire [7:0] analog_input_enable_out,
  input wire dac_reference_current_out,
  input wire conversion_done_irq_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  reg [11:0] raddr;
  reg [10:0] run;
  // run restarts at each result so repeat mode is measured per conversion
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      raddr <= 12'h000;
      run <= 11'h000;
    end else begin
      if (s_axi_arvalid_in && s_axi_arready_out)
        raddr <= s_axi_araddr_in;
      if (conversion_done_irq_out)
        run <= 11'h000;
      else if (dac_reference_current_out)
        run <= run + 11'h001;
    end
  end
  property p_gate_hot; $onehot0(analog_input_enable_out); endproperty
  a_gate_hot: assert property (p_gate_hot) else $error("input gate not one-hot");
  property p_lp_gate; low_power_in |-> ##[1:2] analog_input_enable_out == 8'h00; endproperty
  a_lp_gate: assert property (p_lp_gate) else $error("gate kept in low power");
  property p_lp_ref; low_power_in |-> ##[1:2] !dac_reference_current_out; endproperty
  a_lp_ref: assert property (p_lp_ref) else $error("reference on in low power");
  property p_lp_irq; low_power_in ##1 low_power_in |=> !conversion_done_irq_out; endproperty
  a_lp_irq: assert property (p_lp_irq) else $error("result in low power");
  property p_irq_pulse; conversion_done_irq_out |=> !conversion_done_irq_out; endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("done pulse too long");
  property p_irq_len; conversion_done_irq_out |-> run >= 11'd36; endproperty
  a_irq_len: assert property (p_irq_len) else $error("conversion too short");
  property p_resh; s_axi_rvalid_out && raddr == `SACS_ADDR_RESH |-> s_axi_rdata_out[31:2] == 0;
  endproperty
  a_resh: assert property (p_resh) else $error("result high upper bits set");
  property p_c2_zero;
    s_axi_rvalid_out && raddr == `SACS_ADDR_CTRL2 |-> s_axi_rdata_out[5:3] == 3'b000;
  endproperty
  a_c2_zero: assert property (p_c2_zero) else $error("control two bits 5..3 set");
  property p_start_clr;
    s_axi_rvalid_out && raddr == `SACS_ADDR_CTRL1 && dac_reference_current_out
      |-> !s_axi_rdata_out[7];
  endproperty
  a_start_clr: assert property (p_start_clr) else $error("start bit reads one");
  property p_rhold; s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out; endproperty
  a_rhold: assert property (p_rhold) else $error("read answer dropped");
  c_irq: cover property (conversion_done_irq_out);
  c_lp: cover property (low_power_in ##1 !low_power_in);
  c_err: cover property (s_axi_rvalid_out && s_axi_rresp_out == `SACS_RESP_SLVERR);
endmodule // sacs_adc_chk
bind sacs_adc_ctrl sacs_adc_chk u_chk (.*);

/* File: verif/sacs_comp_model.sv */
`timescale 1ns/100ps
// analog front end stand-in: eight fixed input levels feeding one comparator
module sacs_comp_model #(
  parameter SETTLE = 2
) (
  input wire [7:0] analog_input_enable_in,
  input wire [9:0] dac_code_in,
  output wire comparator_out
);
  reg [9:0] level;
  integer i;
  // with no input gated on, the sampled node sits at ground
  always @* begin
    level = 10'h000;
    for (i = 0; i < 8; i = i + 1)
      if (analog_input_enable_in[i])
        level = 10'h0C3 + i * 10'h071;
  end
  assign #SETTLE comparator_out = level >= dac_code_in;
endmodule // sacs_comp_model

/* File: verif/sar_adc_control_sequencer_bench.sv */
`timescale 1ns/100ps
`include "sacs_defines.vh"
module sar_adc_control_sequencer_bench;
  logic clk_in = 0, rst_b_in = 0, low_power_in = 0;
  logic [11:0] s_axi_awaddr_in = '0, s_axi_araddr_in = '0;
  logic [31:0] s_axi_wdata_in = '0, s_axi_rdata_out;
  logic [3:0] s_axi_wstrb_in = 4'hF;
  logic s_axi_awvalid_in = 0, s_axi_wvalid_in = 0, s_axi_bready_in = 0;
  logic s_axi_arvalid_in = 0, s_axi_rready_in = 0;
  logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out;
  logic s_axi_rvalid_out, comparator_in, dac_reference_current_out, conversion_done_irq_out;
  logic [1:0] s_axi_bresp_out, s_axi_rresp_out;
  logic [7:0] analog_input_enable_out;
  logic [9:0] dac_code_out;
  int n_fail = 0, n_checks = 0, cyc = 0, n_irq = 0;
  int tt[6] = '{39, 78, 156, 312, 624, 1248};
  sacs_adc_ctrl uut (.*);
  sacs_comp_model u_model (.analog_input_enable_in(analog_input_enable_out),
    .dac_code_in(dac_code_out), .comparator_out(comparator_in));
  initial forever #20 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (conversion_done_irq_out === 1'b1) n_irq <= n_irq + 1;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    if (n_fail == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // outputs read right after an edge still hold what that edge sampled
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
    @(posedge clk_in);
    s_axi_awaddr_in <= a;
    s_axi_wdata_in <= {24'h00_0000, d};
    s_axi_awvalid_in <= 1'b1;
    s_axi_wvalid_in <= 1'b1;
    s_axi_bready_in <= 1'b1;
    for (int k = 0; k < 50 && s_axi_bvalid_out !== 1'b1; k++) begin
      @(posedge clk_in);
      if (s_axi_awready_out === 1'b1) s_axi_awvalid_in <= 1'b0;
      if (s_axi_wready_out === 1'b1) s_axi_wvalid_in <= 1'b0;
    end
    chk(s_axi_bvalid_out, 32'h0000_0001);
    s_axi_bready_in <= 1'b0;
    chk(s_axi_bresp_out, er);
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d, input logic [1:0] er);
    @(posedge clk_in);
    s_axi_araddr_in <= a;
    s_axi_arvalid_in <= 1'b1;
    s_axi_rready_in <= 1'b1;
    for (int k = 0; k < 50 && s_axi_rvalid_out !== 1'b1; k++) begin
      @(posedge clk_in);
      if (s_axi_arready_out === 1'b1) s_axi_arvalid_in <= 1'b0;
    end
    chk(s_axi_rvalid_out, 32'h0000_0001);
    d = s_axi_rdata_out;
    s_axi_rready_in <= 1'b0;
    chk(s_axi_rresp_out, er);
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] v;
    rd(a, v, `SACS_RESP_OKAY);
    chk(v, exp);
  endtask
  task automatic wait_end();
    logic [31:0] v;
    v = '0;
    for (int k = 0; k < 600 && v[7] !== 1'b1; k++) rd(`SACS_ADDR_CTRL2, v, `SACS_RESP_OKAY);
  endtask
  initial begin
    logic [31:0] v;
    int t0, n0, ch, tc, ex, bnd;
    repeat (2) @(posedge clk_in);
    rst_b_in <= 1'b1;
    for (int a = 'hD0; a < 'hE0; a += 4) rc(a[11:0], 32'h0000_0000);
    rd(12'h0E0, v, `SACS_RESP_SLVERR);
    chk(v, 32'h0000_0000);
    wr(12'h0E4, 8'h01, `SACS_RESP_SLVERR);
    wr(`SACS_ADDR_CTRL2, 8'hF5, `SACS_RESP_OKAY); // bit 3 written zero
    rc(`SACS_ADDR_CTRL2, 32'h0000_0005);
    s_axi_wstrb_in <= 4'h0;
    wr(`SACS_ADDR_CTRL2, 8'h01, `SACS_RESP_OKAY);
    s_axi_wstrb_in <= 4'hF;
    rc(`SACS_ADDR_CTRL2, 32'h0000_0005);
    for (int k = 0; k < 8; k++) begin
      tc = k < 6 ? k : 0;
      ch = k < 6 ? k : (k == 6 ? 8 : 2);
      ex = (k == 7 || ch > 7) ? 0 : 'h0C3 + ch * 'h71;
      bnd = tc < 2 ? 10 : (tc < 4 ? 32 : 128);
      wr(`SACS_ADDR_CTRL2, tc[7:0], `SACS_RESP_OKAY); // halted while timing set
      wr(`SACS_ADDR_CTRL1, {3'b001, k != 7, ch[3:0]}, `SACS_RESP_OKAY);
      t0 = cyc;
      n0 = n_irq;
      wr(`SACS_ADDR_CTRL1, {3'b101, k != 7, ch[3:0]}, `SACS_RESP_OKAY);
      repeat (4) @(posedge clk_in);
      rc(`SACS_ADDR_CTRL1, {3'b001, k != 7, ch[3:0]});
      rc(`SACS_ADDR_CTRL2, 32'h40 | tc);
      wait_end();
      chk(cyc - t0 >= tt[tc] && cyc - t0 <= tt[tc] + bnd + 16, 1);
      chk(n_irq - n0, 1);
      rc(`SACS_ADDR_CTRL2, 32'h80 | tc);
      rc(`SACS_ADDR_RESL, ex & 'hFF);
      rc(`SACS_ADDR_RESH, ex >> 8);
      rc(`SACS_ADDR_CTRL2, tc);
    end
    wr(`SACS_ADDR_CTRL1, 8'hB3, `SACS_RESP_OKAY);
    wait_end();
    wr(`SACS_ADDR_CTRL1, 8'hB3, `SACS_RESP_OKAY);
    rd(`SACS_ADDR_CTRL2, v, `SACS_RESP_OKAY);
    chk(v[7], 0);
    wait_end();
    for (int m = 0; m < 4; m += 2) begin
      wr(`SACS_ADDR_CTRL1, {1'b1, m[1:0], 5'h13}, `SACS_RESP_OKAY);
      repeat (8) @(posedge clk_in);
      rd(`SACS_ADDR_CTRL2, v, `SACS_RESP_OKAY);
      chk(v[6], 0);
    end
    wr(`SACS_ADDR_CTRL1, 8'hF5, `SACS_RESP_OKAY);
    n0 = n_irq;
    for (int k = 0; k < 400 && n_irq - n0 < 2; k++) @(posedge clk_in);
    chk(n_irq - n0, 2);
    rd(`SACS_ADDR_CTRL2, v, `SACS_RESP_OKAY);
    chk(v[6], 1);
    wr(`SACS_ADDR_CTRL1, 8'h15, `SACS_RESP_OKAY); // only a stop while busy
    rd(`SACS_ADDR_CTRL2, v, `SACS_RESP_OKAY);
    chk(v & 'hC0, 0);
    rc(`SACS_ADDR_RESL, 0);
    rc(`SACS_ADDR_RESH, 0);
    wr(`SACS_ADDR_CTRL1, 8'hF5, `SACS_RESP_OKAY);
    repeat (60) @(posedge clk_in);
    low_power_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    low_power_in <= 1'b0;
    rd(`SACS_ADDR_CTRL1, v, `SACS_RESP_OKAY);
    chk(v[7:4], 0);
    rc(`SACS_ADDR_CTRL2, 0);
    rc(`SACS_ADDR_RESH, 0);
    summarize();
  end
  // all conversions plus polling stay far below this span
  initial begin
    #800000;
    n_fail++;
    summarize();
  end
endmodule // sar_adc_control_sequencer_bench
